// *** design/omc_defs.vh ***
// Constants for the operating-mode controller.
// Included by omc_mode_ctrl.v; definitions only.
`ifndef OMC_DEFS_VH
`define OMC_DEFS_VH

// Mode encodings reported on o_mode (one-hot state codes)
`define OMC_ST_RESET      6'h01
`define OMC_ST_RUN        6'h02
`define OMC_ST_HALT       6'h04
`define OMC_ST_WAIT       6'h08
`define OMC_ST_LSTOP      6'h10
`define OMC_ST_DSTOP      6'h20

// Debug command classes on i_cmd_class
`define OMC_CMD_MEM       3'h0
`define OMC_CMD_MEM_STAT  3'h1
`define OMC_CMD_CTL_REG   3'h2
`define OMC_CMD_HALT      3'h3
`define OMC_CMD_CPU_REG   3'h4
`define OMC_CMD_TRACE     3'h5
`define OMC_CMD_RESUME    3'h6

// Command answer status
`define OMC_STAT_OK       2'h0
`define OMC_STAT_LOWPWR   2'h1
`define OMC_STAT_REJECT   2'h2

// Reset vector location
`define OMC_RESET_VEC_HI  16'hFFFE
`define OMC_RESET_VEC_LO  16'hFFFF

// Register map (word addresses)
`define OMC_ADDR_SYSOPT   4'h0
`define OMC_ADDR_STATUS   4'h1
`define OMC_ADDR_CCODE    4'h2

// System options field positions and reset value
`define OMC_SYSOPT_STOP_EN  7
`define OMC_SYSOPT_I2C_SEL  1
`define OMC_SYSOPT_UART_SEL 0
`define OMC_SYSOPT_RST      8'h00

// Condition code register: interrupt mask bit and reset value
`define OMC_CCODE_IMASK   3
`define OMC_CCODE_RST     8'h08

// Status register field positions
`define OMC_STAT_ILLOP    7

`endif

// *** design/omc_mode_ctrl.v ***
// Operating-mode controller of an 8-bit core: run, debug halt, wait, stop.
// Assumes one 100 MHz clock, synchronous inputs, CPU/debug pulses.
`timescale 1ns/100ps
`include "omc_defs.vh"

module omc_mode_ctrl #(
    parameter DW = 8,
    parameter AW = 4
) (
    input  wire          i_clk_sys,
    input  wire          i_arst_n,
    // Register port
    input  wire [AW-1:0] i_addr,
    input  wire [DW-1:0] i_wdata,
    input  wire          i_wr,
    input  wire          i_rd,
    output reg  [DW-1:0] o_rdata,
    // Mode select pin level
    input  wire          i_mode_select_debug_pin,
    // CPU events (one-cycle pulses)
    input  wire          i_software_halt_instruction,
    input  wire          i_sleep_instruction,
    input  wire          i_stop_instruction,
    input  wire          i_deep_stop_sel,
    input  wire          i_irq,
    input  wire          i_wake_event,
    input  wire          i_bp_debug_serial_controller,
    input  wire          i_bp_onchip_breakpoint_unit,
    input  wire          i_cpu_imask_set,
    // Debug command from the serial controller
    input  wire          i_cmd_valid,
    input  wire [2:0]    i_cmd_class,
    output reg           o_cmd_done,
    output reg           o_cmd_exec,
    output reg  [1:0]    o_cmd_status,
    // CPU / power control
    output wire [5:0]    o_mode,
    output reg           o_cpu_clk_en,
    output reg           o_vector_fetch,
    output reg  [15:0]   o_vector_addr,
    output reg           o_irq_stack_start,
    output reg           o_illegal_op_reset,
    output wire          o_sys_clk_en,
    output wire          o_reg_full,
    output wire          o_core_power,
    // Pin routing
    input  wire          i_i2c1_scl_oe,
    input  wire          i_i2c1_sda_oe,
    input  wire          i_uart2_txd_oe,
    output wire [3:0]    o_portf_alt_sel,
    output wire          o_i2c1_alt_loc,
    output wire          o_uart2_alt_loc
);

    localparam ST_RESET = `OMC_ST_RESET;
    localparam ST_RUN   = `OMC_ST_RUN;
    localparam ST_HALT  = `OMC_ST_HALT;
    localparam ST_WAIT  = `OMC_ST_WAIT;
    localparam ST_LSTOP = `OMC_ST_LSTOP;
    localparam ST_DSTOP = `OMC_ST_DSTOP;

    reg [5:0]    state_reg;
    reg [5:0]    state_next;
    reg [DW-1:0] sysopt_reg;
    reg [DW-1:0] ccode_reg;
    reg          illop_reg;
    reg          vec_phase_reg;
    reg          cmd_ok;
    reg          cmd_exec_c;
    reg [1:0]    cmd_stat_c;

    wire halt_cmd = i_cmd_valid && (i_cmd_class == `OMC_CMD_HALT);
    wire go_cmd   = i_cmd_valid && (i_cmd_class == `OMC_CMD_RESUME);
    wire halt_req = halt_cmd || i_software_halt_instruction ||
                    i_bp_debug_serial_controller ||
                    i_bp_onchip_breakpoint_unit;
    wire stop_ok  = sysopt_reg[`OMC_SYSOPT_STOP_EN];

    assign o_mode = state_reg;

    // Command acceptance per mode
    always @* begin
        cmd_ok     = 1'b0;
        cmd_exec_c = 1'b0;
        cmd_stat_c = `OMC_STAT_REJECT;
        case (i_cmd_class)
            `OMC_CMD_MEM, `OMC_CMD_CTL_REG:
                cmd_ok = (state_reg == ST_RUN) ||
                         (state_reg == ST_HALT);
            `OMC_CMD_MEM_STAT:
                cmd_ok = 1'b1;
            `OMC_CMD_HALT:
                // Deep stop cannot honour a halt, so refuse it there
                cmd_ok = (state_reg != ST_RESET) &&
                         (state_reg != ST_DSTOP);
            `OMC_CMD_CPU_REG, `OMC_CMD_TRACE, `OMC_CMD_RESUME:
                cmd_ok = (state_reg == ST_HALT);
            default:
                cmd_ok = 1'b0;
        endcase
        if (cmd_ok) begin
            if (i_cmd_class == `OMC_CMD_MEM_STAT &&
                state_reg != ST_RUN && state_reg != ST_HALT) begin
                cmd_stat_c = `OMC_STAT_LOWPWR;
                cmd_exec_c = 1'b0;
            end else begin
                cmd_stat_c = `OMC_STAT_OK;
                cmd_exec_c = 1'b1;
            end
        end
    end

    // Mode sequencing
    always @* begin
        state_next = state_reg;
        case (state_reg)
            ST_RESET: begin
                if (i_mode_select_debug_pin)
                    state_next = ST_RUN;
                else
                    state_next = ST_HALT;
            end
            ST_RUN: begin
                if (halt_req)
                    state_next = ST_HALT;
                else if (i_sleep_instruction)
                    state_next = ST_WAIT;
                else if (i_stop_instruction && stop_ok)
                    state_next = i_deep_stop_sel ? ST_DSTOP
                                                 : ST_LSTOP;
                else if (i_stop_instruction)
                    state_next = ST_RESET;
            end
            ST_HALT: begin
                if (go_cmd)
                    state_next = ST_RUN;
            end
            ST_WAIT: begin
                if (halt_cmd)
                    state_next = ST_HALT;
                else if (i_irq)
                    state_next = ST_RUN;
            end
            ST_LSTOP: begin
                if (halt_cmd)
                    state_next = ST_HALT;
                else if (i_irq || i_wake_event)
                    state_next = ST_RUN;
            end
            ST_DSTOP: begin
                if (i_wake_event)
                    state_next = ST_RESET;
            end
            default:
                state_next = ST_RESET;
        endcase
    end

    always @(posedge i_clk_sys or negedge i_arst_n) begin
        if (!i_arst_n) begin
            state_reg          <= ST_RESET;
            sysopt_reg         <= `OMC_SYSOPT_RST;
            ccode_reg          <= `OMC_CCODE_RST;
            illop_reg          <= 1'b0;
            vec_phase_reg      <= 1'b0;
            o_rdata            <= {DW{1'b0}};
            o_cmd_done         <= 1'b0;
            o_cmd_exec         <= 1'b0;
            o_cmd_status       <= `OMC_STAT_OK;
            o_cpu_clk_en       <= 1'b0;
            o_vector_fetch     <= 1'b0;
            o_vector_addr      <= 16'h0000;
            o_irq_stack_start  <= 1'b0;
            o_illegal_op_reset <= 1'b0;
        end else begin
            state_reg <= state_next;
            // CPU clocked only in run; halt suspends, wait gates it
            o_cpu_clk_en <= (state_next == ST_RUN);
            // Two-byte reset vector fetch after entering run from reset
            o_vector_fetch <= 1'b0;
            if (state_reg == ST_RESET && state_next == ST_RUN) begin
                o_vector_fetch <= 1'b1;
                o_vector_addr  <= `OMC_RESET_VEC_HI;
                vec_phase_reg  <= 1'b1;
            end else if (vec_phase_reg) begin
                o_vector_fetch <= 1'b1;
                o_vector_addr  <= `OMC_RESET_VEC_LO;
                vec_phase_reg  <= 1'b0;
            end
            o_irq_stack_start <= (state_reg == ST_WAIT) &&
                                 (state_next == ST_RUN);
            o_illegal_op_reset <= (state_reg == ST_RUN) &&
                                  (state_next == ST_RESET);
            // Answer to debug command
            o_cmd_done   <= i_cmd_valid;
            o_cmd_exec   <= i_cmd_valid && cmd_exec_c;
            o_cmd_status <= i_cmd_valid ? cmd_stat_c : `OMC_STAT_OK;
            // Interrupt mask: hardware clear on wait entry wins
            if (state_reg != ST_WAIT && state_next == ST_WAIT)
                ccode_reg[`OMC_CCODE_IMASK] <= 1'b0;
            else if (i_wr && i_addr == `OMC_ADDR_CCODE)
                ccode_reg <= i_wdata;
            else if (i_cpu_imask_set)
                ccode_reg[`OMC_CCODE_IMASK] <= 1'b1;
            if (i_wr && i_addr == `OMC_ADDR_SYSOPT)
                sysopt_reg <= i_wdata;
            // Illegal-op flag: set wins over write-one clear
            if (o_illegal_op_reset)
                illop_reg <= 1'b1;
            else if (i_wr && i_addr == `OMC_ADDR_STATUS &&
                     i_wdata[`OMC_STAT_ILLOP])
                illop_reg <= 1'b0;
            // Read data in the cycle after the strobe
            o_rdata <= {DW{1'b0}};
            if (i_rd) begin
                case (i_addr)
                    `OMC_ADDR_SYSOPT: o_rdata <= sysopt_reg;
                    `OMC_ADDR_STATUS: o_rdata <= {illop_reg, 1'b0,
                                                  state_reg};
                    `OMC_ADDR_CCODE:  o_rdata <= ccode_reg;
                    default:          o_rdata <= {DW{1'b0}};
                endcase
            end
        end
    end

    // Power and clock indications
    assign o_sys_clk_en = (state_reg != ST_LSTOP) &&
                          (state_reg != ST_DSTOP);
    assign o_reg_full   = o_sys_clk_en;
    assign o_core_power = (state_reg != ST_DSTOP);

    // Pin routing
    assign o_i2c1_alt_loc  = sysopt_reg[`OMC_SYSOPT_I2C_SEL];
    assign o_uart2_alt_loc = sysopt_reg[`OMC_SYSOPT_UART_SEL];

    // Port F line n given to its peripheral when that peripheral drives at its default location; line 1 whenever UART2 is at its default location
    genvar gi;
    generate
        for (gi = 0; gi < 4; gi = gi + 1) begin : g_pf
            wire per_en;
            if (gi == 0) begin : g_tx
                assign per_en = !o_uart2_alt_loc && i_uart2_txd_oe;
            end else if (gi == 1) begin : g_rx
                assign per_en = !o_uart2_alt_loc;
            end else if (gi == 2) begin : g_scl
                assign per_en = !o_i2c1_alt_loc && i_i2c1_scl_oe;
            end else begin : g_sda
                assign per_en = !o_i2c1_alt_loc && i_i2c1_sda_oe;
            end
            assign o_portf_alt_sel[gi] = per_en;
        end
    endgenerate

endmodule

// *** sim/omc_dbg_host.sv ***
// Debug host model: one command pulse per send call.
// Assumes the controller samples commands on the rising edge.
`timescale 1ns/100ps
module omc_dbg_host (
    input  wire       i_clk_sys,
    output reg        o_cmd_valid = 1'b0,
    output reg  [2:0] o_cmd_class = 3'h7
);
    // Idle gap makes the host slow; class is scrambled when idle
    task send(input [2:0] c, input integer gap);
        repeat (gap) @(posedge i_clk_sys);
        o_cmd_valid <= 1'b1;
        o_cmd_class <= c;
        @(posedge i_clk_sys);
        o_cmd_valid <= 1'b0;
        o_cmd_class <= ~c;
    endtask
endmodule

// *** sim/omc_mode_ctrl_checker.sv ***
// Assertions on the mode controller ports.
// Bound to every omc_mode_ctrl instance by port name.
`timescale 1ns/100ps
`include "omc_defs.vh"
module omc_mode_ctrl_checker (
    input wire       i_clk_sys,
    input wire       i_arst_n,
    input wire       i_software_halt_instruction,
    input wire       i_sleep_instruction,
    input wire       i_irq,
    input wire       i_bp_debug_serial_controller,
    input wire       i_bp_onchip_breakpoint_unit,
    input wire       i_cmd_valid,
    input wire [2:0] i_cmd_class,
    input wire       o_cmd_exec,
    input wire [1:0] o_cmd_status,
    input wire [5:0] o_mode,
    input wire       o_cpu_clk_en,
    input wire       o_irq_stack_start
);
    default clocking @(posedge i_clk_sys); endclocking
    default disable iff (!i_arst_n);
    wire run = o_mode == `OMC_ST_RUN;
    wire hlt = o_mode == `OMC_ST_HALT;
    wire wt  = o_mode == `OMC_ST_WAIT;
    wire swh = i_software_halt_instruction;
    wire bp  = i_bp_debug_serial_controller | i_bp_onchip_breakpoint_unit;
    wire cv  = i_cmd_valid;
    wire hc  = cv && i_cmd_class == `OMC_CMD_HALT;
    wire rs  = cv && i_cmd_class == `OMC_CMD_RESUME;
    wire ms  = cv && i_cmd_class == `OMC_CMD_MEM_STAT;
    wire cpu = (i_cmd_class == `OMC_CMD_CPU_REG) |
               (i_cmd_class == `OMC_CMD_TRACE);
    AST_HALT_CMD: assert property (run && hc |=> hlt && o_cmd_exec)
        else $error("halt command ignored");
    AST_SW_HALT: assert property (run && swh |=> hlt)
        else $error("halt instruction ignored");
    AST_BP_HALT: assert property (run && bp |=> hlt)
        else $error("breakpoint ignored");
    AST_CPU_ONLY: assert property (
        cv && cpu && !hlt |=> o_cmd_status == `OMC_STAT_REJECT && !o_cmd_exec)
        else $error("halt-only command accepted");
    AST_RESUME: assert property (hlt && rs |=> run && o_cmd_exec)
        else $error("resume ignored");
    AST_SLEEP: assert property (
        run && i_sleep_instruction && !swh && !bp && !hc |=> wt && !o_cpu_clk_en)
        else $error("sleep did not gate cpu");
    AST_WAKE: assert property (
        wt && i_irq && !hc |=> run ##[0:1] o_irq_stack_start)
        else $error("irq did not wake");
    AST_LOWPWR: assert property (
        wt && ms |=> o_cmd_status == `OMC_STAT_LOWPWR && !o_cmd_exec)
        else $error("status access in wait");
endmodule
bind omc_mode_ctrl omc_mode_ctrl_checker u_chk (.*);

// *** sim/tb_operating_mode_control.sv ***
// Self-checking bench for the mode controller.
// Host model sends commands; queues hold expected answers.
`timescale 1ns/100ps
`include "omc_defs.vh"
module tb_operating_mode_control;
    reg         i_clk_sys = 1'b0;
    reg         i_arst_n = 1'b0;
    reg  [3:0]  i_addr = 4'h0;
    reg  [7:0]  i_wdata = 8'h00;
    reg         i_wr = 1'b0;
    reg         i_rd = 1'b0;
    reg         i_mode_select_debug_pin = 1'b1;
    reg         i_deep_stop_sel = 1'b0;
    reg         i_irq = 1'b0;
    reg         i_cpu_imask_set = 1'b0;
    reg  [2:0]  oe = 3'h0;
    reg  [5:0]  ev = 6'h00;
    reg         rd_d = 1'b0;
    reg  [31:0] seed = 32'h00000025;
    reg  [31:0] r;
    integer     n_fail = 0;
    integer     tests_run = 0;
    integer     cyc = 0;
    integer     i;
    reg  [2:0]  cq[$];
    reg  [7:0]  rq[$];
    wire        i_cmd_valid;
    wire [2:0]  i_cmd_class;
    wire [7:0]  o_rdata;
    wire [1:0]  o_cmd_status;
    wire [5:0]  o_mode;
    wire [15:0] o_vector_addr;
    wire [3:0]  o_portf_alt_sel;
    wire        o_cmd_done, o_cmd_exec, o_cpu_clk_en, o_vector_fetch;
    wire        o_irq_stack_start, o_illegal_op_reset, o_sys_clk_en;
    wire        o_reg_full, o_core_power, o_i2c1_alt_loc, o_uart2_alt_loc;
    wire        i_software_halt_instruction = ev[0];
    wire        i_sleep_instruction = ev[1];
    wire        i_stop_instruction = ev[2];
    wire        i_wake_event = ev[3];
    wire        i_bp_debug_serial_controller = ev[4];
    wire        i_bp_onchip_breakpoint_unit = ev[5];
    wire        i_uart2_txd_oe = oe[0];
    wire        i_i2c1_scl_oe = oe[1];
    wire        i_i2c1_sda_oe = oe[2];
    wire [2:0]  pwr = {o_sys_clk_en, o_reg_full, o_core_power};
    wire [15:0] vec = o_vector_addr & {16{o_vector_fetch}};
    omc_mode_ctrl u_dut (.*);
    omc_dbg_host u_host (.i_clk_sys(i_clk_sys), .o_cmd_valid(i_cmd_valid),
                         .o_cmd_class(i_cmd_class));
    always #5 i_clk_sys = ~i_clk_sys;
    function [31:0] rnd();
        seed = seed ^ (seed << 13);
        seed = seed ^ (seed >> 17);
        seed = seed ^ (seed << 5);
        return seed;
    endfunction
    task chk(input string n, input [15:0] e, input [15:0] g);
        tests_run++;
        if (e !== g) begin
            n_fail++;
            $display("FAIL %s exp %h got %h", n, e, g);
        end
    endtask
    task end_of_test;
        if (n_fail == 0 && tests_run > 0)
            $display("Finished cleanly");
        else
            $display("Finished with errors");
        $finish;
    endtask
    task pulse(input integer k);
        ev[k] <= 1'b1;
        @(posedge i_clk_sys);
        ev[k] <= 1'b0;
        #1;
    endtask
    // Expected answer is {exec, status}
    task cmd(input [2:0] c, input [2:0] e);
        cq.push_back(e);
        u_host.send(c, rnd() % 3);
        #1;
    endtask
    task wr(input [3:0] a, input [7:0] d);
        i_addr <= a;
        i_wdata <= d;
        i_wr <= 1'b1;
        @(posedge i_clk_sys);
        i_wr <= 1'b0;
        #1;
    endtask
    task rd(input [3:0] a, input [7:0] e);
        rq.push_back(e);
        i_addr <= a;
        i_rd <= 1'b1;
        @(posedge i_clk_sys);
        i_rd <= 1'b0;
        #1;
    endtask
    always @(posedge i_clk_sys) begin
        cyc <= cyc + 1;
        rd_d <= i_rd;
        if (o_cmd_done === 1'b1)
            chk("cmd", cq.pop_front(), {o_cmd_exec, o_cmd_status});
        if (rd_d)
            chk("rdata", rq.pop_front(), o_rdata);
        if (cyc == 3000) begin
            n_fail++;
            end_of_test;
        end
    end
    initial begin
        repeat (4) @(posedge i_clk_sys);
        i_arst_n <= 1'b1;
        @(posedge i_clk_sys);
        #1 chk("mode", `OMC_ST_RUN, o_mode);
        chk("vec", `OMC_RESET_VEC_HI, vec);
        @(posedge i_clk_sys);
        #1 chk("vec", `OMC_RESET_VEC_LO, vec);
        rd(`OMC_ADDR_SYSOPT, `OMC_SYSOPT_RST);
        rd(`OMC_ADDR_CCODE, `OMC_CCODE_RST);
        rd(4'hF, 8'h00);
        for (i = 0; i < 4; i++) begin
            r = rnd();
            oe <= r[4:2];
            wr(`OMC_ADDR_SYSOPT, {6'h00, r[1:0]});
            rd(`OMC_ADDR_SYSOPT, {6'h00, r[1:0]});
            chk("loc", r[1:0], {o_i2c1_alt_loc, o_uart2_alt_loc});
            r[7:4] = {r[4:3] & ~{2{r[1]}}, ~r[0], r[2] & ~r[0]};
            chk("portf", r[7:4], o_portf_alt_sel);
        end
        for (i = 0; i < 7; i++)
            if (i != 3)
                cmd(i[2:0], i < 3 ? 3'h4 : 3'h2);
        cmd(`OMC_CMD_HALT, 3'h4);
        chk("mode", `OMC_ST_HALT, o_mode);
        chk("cpuclk", 16'h0000, o_cpu_clk_en);
        for (i = 0; i < 6; i++)
            cmd(i[2:0], 3'h4);
        cmd(`OMC_CMD_RESUME, 3'h4);
        chk("mode", `OMC_ST_RUN, o_mode);
        pulse(1);
        chk("mode", `OMC_ST_WAIT, o_mode);
        chk("pwr", 16'h0007, pwr);
        rd(`OMC_ADDR_CCODE, 8'h00);
        for (i = 0; i < 7; i++)
            if (i != 3)
                cmd(i[2:0], i == 1 ? 3'h1 : 3'h2);
        i_irq <= 1'b1;
        @(posedge i_clk_sys);
        i_irq <= 1'b0;
        #1 chk("mode", `OMC_ST_RUN, o_mode);
        i_cpu_imask_set <= 1'b1;
        @(posedge i_clk_sys);
        i_cpu_imask_set <= 1'b0;
        #1 rd(`OMC_ADDR_CCODE, `OMC_CCODE_RST);
        pulse(1);
        cmd(`OMC_CMD_HALT, 3'h4);
        chk("mode", `OMC_ST_HALT, o_mode);
        for (i = 0; i < 3; i++) begin
            cmd(`OMC_CMD_RESUME, 3'h4);
            pulse(i == 0 ? 0 : i + 3);
            chk("mode", `OMC_ST_HALT, o_mode);
        end
        cmd(`OMC_CMD_RESUME, 3'h4);
        pulse(2);
        chk("illop", 16'h0001, o_illegal_op_reset);
        @(posedge i_clk_sys);
        rd(`OMC_ADDR_STATUS, {2'h2, `OMC_ST_RUN});
        wr(`OMC_ADDR_STATUS, 8'h80);
        rd(`OMC_ADDR_STATUS, {2'h0, `OMC_ST_RUN});
        wr(`OMC_ADDR_SYSOPT, 8'h80);
        pulse(2);
        chk("mode", `OMC_ST_LSTOP, o_mode);
        chk("pwr", 16'h0001, pwr);
        pulse(3);
        chk("mode", `OMC_ST_RUN, o_mode);
        i_deep_stop_sel <= 1'b1;
        pulse(2);
        chk("pwr", 16'h0000, pwr);
        pulse(3);
        chk("mode", `OMC_ST_RESET, o_mode);
        i_arst_n <= 1'b0;
        i_mode_select_debug_pin <= 1'b0;
        @(posedge i_clk_sys);
        i_arst_n <= 1'b1;
        @(posedge i_clk_sys);
        #1 chk("mode", `OMC_ST_HALT, o_mode);
        repeat (3) @(posedge i_clk_sys);
        end_of_test;
    end
endmodule
